/* File: logic/fpfc_controller.sv */
// Fan PWM controller with shutdown, over-temperature and missing-pulse fault sequencer
// ==========================================================
// Summary of operation
// - duty follows larger of temperature, minimum level
// - level compared with ramp, floor 0%, ceiling 100%
// - sawtooth ramp period is one PWM cycle
// - drive spans off to on, low in shutdown
// - low minimum level shuts down, fault inactive
// - release above threshold reruns start-up window
// - fault asserted at over-temperature threshold
// - over-temperature clears below threshold minus hysteresis
// - 32 pulse-free cycles start 3-cycle diagnostic
// - pulse in diagnostic returns to PWM
// - quiet diagnostic runs 32-cycle start-up window
// - start-up pulse resumes PWM, else fan fault
// - fan fault holds fault low, drive high
// - 16 pulses in 32 cycles clears fault
// - shutdown during fault releases fault, drive low
// - fault forces full drive; recovery follows larger of temperature, minimum
// - power-up drives high 32 cycles watching pulses
// - each pulse restarts missing-pulse counter
// - blanking and first pulse after turn-on ignored
module fpfc_controller
	import fpfc_pkg::*;
#(
	parameter int STEP_CYCLES = DEFAULT_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                rst_n,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0]   address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	input  wire logic [3:0]          byteenable,
	output logic [31:0]              readdata,
	output logic                     waitrequest,
	// Fan pins
	input  wire logic                sense,
	output logic                     drive_q,
	// Open-drain fault pin
	input  wire logic                fault_in,
	output logic                     fault_out,
	output logic                     fault_oe
);

	// ==========================================================
	// Bus slave
	logic                ack_q;
	logic [LEVEL_W-1:0]  temp_q;
	logic [LEVEL_W-1:0]  min_q;
	logic                shut_q;
	logic                overtemp_q;
	logic [31:0]         level_word;
	logic [31:0]         status_word;
	logic [31:0]         ramp_word;
	logic [31:0]         rd_word;
	wire                 req_w;
	wire                 wr_level_w;
	fpfc_state_e         st_q;
	fpfc_state_e         st_d;
	logic [LEVEL_W-1:0]  ramp_q;
	logic                period_end;
	logic                pulse;

	assign req_w       = read | write;
	assign waitrequest = req_w & ~ack_q;
	assign wr_level_w  = write & ack_q & (address == REG_LEVEL);
	assign level_word  = {16'h0000, min_q, temp_q};
	assign status_word = {21'h000000, st_q, 3'h0, fault_in, shut_q, overtemp_q, fault_oe, drive_q};
	assign ramp_word   = {24'h000000, ramp_q};
	assign rd_word     = (address == REG_LEVEL)  ? level_word :
	                     (address == REG_STATUS) ? status_word :
	                     (address == REG_RAMP)   ? ramp_word : 32'h00000000;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_q    <= 1'b0;
			readdata <= 32'h00000000;
			temp_q   <= TEMP_RESET;
			min_q    <= MIN_RESET;
		end else begin
			ack_q <= req_w & ~ack_q;
			if (read && !ack_q) begin
				readdata <= rd_word;
			end
			if (wr_level_w && byteenable[0]) begin
				temp_q <= writedata[LEVEL_W-1:0];
			end
			if (wr_level_w && byteenable[1]) begin
				min_q <= writedata[2*LEVEL_W-1:LEVEL_W];
			end
		end
	end

	// ==========================================================
	// Ramp, sense and duty compare
	fpfc_ramp #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_ramp (
		.clock      (clock),
		.rst_n      (rst_n),
		.ramp_q     (ramp_q),
		.period_end (period_end)
	);

	fpfc_sense u_sense (
		.clock   (clock),
		.rst_n   (rst_n),
		.sense   (sense),
		.drive   (drive_q),
		.pulse_q (pulse)
	);

	wire [LEVEL_W-1:0] level_sel_w;
	wire               pwm_on_w;
	wire               drive_d;
	wire               fault_d;

	assign level_sel_w = (temp_q > min_q) ? temp_q : min_q;
	assign pwm_on_w    = (level_sel_w > ramp_q) | (level_sel_w >= RAMP_CEILING_LEVEL);
	// Continuous drive outside PWM; low whenever shut down
	assign drive_d     = ~shut_q & ((st_q == ST_RUN) ? pwm_on_w : (st_q != ST_SHUTDOWN));
	assign fault_d     = ~shut_q & ((st_q == ST_FAULT) | overtemp_q);
	assign fault_out   = 1'b0;

	// ==========================================================
	// Shutdown and over-temperature levels
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shut_q     <= 1'b0;
			overtemp_q <= 1'b0;
		end else begin
			if (min_q < SHUTDOWN_THRESHOLD) begin
				shut_q <= 1'b1;
			end else if (min_q > RELEASE_THRESHOLD) begin
				shut_q <= 1'b0;
			end
			if (temp_q >= OVERTEMP_THRESHOLD) begin
				overtemp_q <= 1'b1;
			end else if (temp_q < OVERTEMP_RELEASE) begin
				overtemp_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Fault sequencer
	logic [CYC_W-1:0] cyc_q;
	logic [CYC_W-1:0] cyc_d;
	logic [CYC_W-1:0] miss_q;
	logic [CYC_W-1:0] miss_d;
	logic [CYC_W-1:0] pcnt_q;
	logic [CYC_W-1:0] pcnt_d;

	always_comb begin
		st_d   = st_q;
		cyc_d  = cyc_q;
		miss_d = miss_q;
		pcnt_d = pcnt_q;
		if (shut_q) begin
			st_d  = ST_SHUTDOWN;
			cyc_d = '0;
		end else begin
			unique case (st_q)
				ST_SHUTDOWN: begin
					// Wait for a ramp boundary so the window holds 32 whole cycles
					if (period_end) begin
						st_d  = ST_STARTUP;
						cyc_d = '0;
					end
				end
				ST_STARTUP: begin
					if (pulse) begin
						st_d   = ST_RUN;
						miss_d = '0;
					end else if (period_end) begin
						if (cyc_q == START_LAST) begin
							st_d   = ST_FAULT;
							cyc_d  = '0;
							pcnt_d = '0;
						end else begin
							cyc_d = cyc_q + 1'b1;
						end
					end
				end
				ST_RUN: begin
					if (pulse) begin
						miss_d = '0;
					end else if (period_end) begin
						if (miss_q == MISS_LAST) begin
							st_d  = ST_DIAG;
							cyc_d = '0;
						end else begin
							miss_d = miss_q + 1'b1;
						end
					end
				end
				ST_DIAG: begin
					if (pulse) begin
						st_d   = ST_RUN;
						miss_d = '0;
					end else if (period_end) begin
						if (cyc_q == DIAG_LAST) begin
							st_d  = ST_STARTUP;
							cyc_d = '0;
						end else begin
							cyc_d = cyc_q + 1'b1;
						end
					end
				end
				ST_FAULT: begin
					if (pulse && pcnt_q == RECOVER_LAST) begin
						st_d   = ST_RUN;
						miss_d = '0;
					end else begin
						if (pulse) begin
							pcnt_d = pcnt_q + 1'b1;
						end
						if (period_end) begin
							cyc_d = cyc_q + 1'b1;
							if (cyc_q == WIN_LAST) begin
								// Window over: recount from the next pulse
								cyc_d  = '0;
								pcnt_d = '0;
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q     <= ST_STARTUP;
			cyc_q    <= '0;
			miss_q   <= '0;
			pcnt_q   <= '0;
			drive_q  <= 1'b0;
			fault_oe <= 1'b0;
		end else begin
			st_q     <= st_d;
			cyc_q    <= cyc_d;
			miss_q   <= miss_d;
			pcnt_q   <= pcnt_d;
			drive_q  <= drive_d;
			fault_oe <= fault_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence diag_quiet_s;
		st_q == ST_DIAG && period_end && cyc_q == DIAG_LAST && !pulse && !shut_q;
	endsequence
	sequence start_quiet_s;
		st_q == ST_STARTUP && period_end && cyc_q == START_LAST && !pulse && !shut_q;
	endsequence

	shutdown_drive_a: assert property (shut_q |=> !drive_q && !fault_oe)
		else $error("drive or fault active during shutdown");
	release_start_a: assert property (st_q == ST_SHUTDOWN ##1 st_q != ST_SHUTDOWN |-> st_q == ST_STARTUP)
		else $error("release did not enter start-up window");
	overtemp_set_a: assert property (temp_q >= OVERTEMP_THRESHOLD && !shut_q |=> ##1 fault_oe)
		else $error("over-temperature did not assert fault");
	overtemp_hold_a: assert property (overtemp_q && temp_q >= OVERTEMP_RELEASE |=> overtemp_q)
		else $error("over-temperature cleared inside hysteresis");
	diag_entry_a: assert property (st_q == ST_RUN && period_end && miss_q == MISS_LAST && !pulse && !shut_q
		|=> st_q == ST_DIAG ##1 drive_q)
		else $error("missing pulses did not start diagnostic");
	diag_pulse_a: assert property (st_q == ST_DIAG && pulse && !shut_q |=> st_q == ST_RUN && !fault_oe || overtemp_q)
		else $error("pulse in diagnostic did not resume PWM");
	diag_end_a: assert property (diag_quiet_s |=> st_q == ST_STARTUP && cyc_q == '0)
		else $error("quiet diagnostic did not start start-up window");
	start_fail_a: assert property (start_quiet_s |=> st_q == ST_FAULT ##1 fault_oe)
		else $error("quiet start-up window did not flag fan fault");
	fault_drive_a: assert property (st_q == ST_FAULT && !shut_q |=> drive_q && fault_oe)
		else $error("fan fault without full drive and fault low");
	recover_a: assert property (st_q == ST_FAULT && pulse && pcnt_q == RECOVER_LAST && !shut_q
		|=> st_q == ST_RUN)
		else $error("sixteenth pulse did not clear fan fault");
	min_duty_a: assert property (st_q == ST_RUN && !shut_q && min_q > ramp_q |=> drive_q)
		else $error("duty fell below minimum level");

endmodule

/* File: logic/fpfc_pkg.sv */
// Constants, register map and state type for the fan PWM fault controller
package fpfc_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLOCK_HZ            = 20_000_000;
	localparam int CLOCK_PERIOD_NS     = 50;
	localparam int PWM_FREQ_HZ         = 30;
	localparam int RAMP_STEPS          = 128;
	localparam int DEFAULT_STEP_CYCLES = CLOCK_HZ / (PWM_FREQ_HZ * RAMP_STEPS);
	localparam int PRE_W               = 13;
	localparam int BLANK_TIME_NS       = 20_000;
	localparam int BLANK_CYCLES        = (BLANK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int BLANK_W             = 9;

	// ==========================================================
	// Level codes
	localparam int             LEVEL_W              = 8;
	localparam logic [7:0]     RAMP_FLOOR_LEVEL     = 8'h40;
	localparam logic [7:0]     RAMP_CEILING_LEVEL   = 8'hBF;
	localparam logic [7:0]     OVERTEMP_THRESHOLD   = 8'hC1;
	localparam logic [7:0]     OVERTEMP_HYSTERESIS  = 8'h07;
	localparam logic [7:0]     OVERTEMP_RELEASE     = OVERTEMP_THRESHOLD - OVERTEMP_HYSTERESIS;
	localparam logic [7:0]     SHUTDOWN_THRESHOLD   = 8'h08;
	localparam logic [7:0]     RELEASE_THRESHOLD    = 8'h10;
	localparam logic [7:0]     TEMP_RESET           = 8'h40;
	localparam logic [7:0]     MIN_RESET            = 8'h40;

	// ==========================================================
	// PWM cycle counts
	localparam int             CYC_W          = 5;
	localparam logic [4:0]     MISS_LAST      = 5'h1F;
	localparam logic [4:0]     DIAG_LAST      = 5'h02;
	localparam logic [4:0]     START_LAST     = 5'h1F;
	localparam logic [4:0]     WIN_LAST       = 5'h1F;
	localparam logic [4:0]     RECOVER_LAST   = 5'h0F;

	// ==========================================================
	// Register map (byte addresses)
	localparam int             ADDR_W      = 4;
	localparam logic [3:0]     REG_LEVEL   = 4'h0;
	localparam logic [3:0]     REG_STATUS  = 4'h4;
	localparam logic [3:0]     REG_RAMP    = 4'h8;

	typedef enum logic [2:0] {
		ST_SHUTDOWN,
		ST_STARTUP,
		ST_RUN,
		ST_DIAG,
		ST_FAULT
	} fpfc_state_e;

endpackage

/* File: logic/fpfc_ramp.sv */
// Sawtooth ramp counter that defines one PWM cycle
module fpfc_ramp
	import fpfc_pkg::*;
#(
	parameter int STEP_CYCLES = DEFAULT_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// Ramp
	output logic [LEVEL_W-1:0]      ramp_q,
	output logic                    period_end
);

	logic [PRE_W-1:0] pre_q;
	wire              step_w;
	wire              top_w;

	assign step_w     = pre_q == PRE_W'(STEP_CYCLES - 1);
	assign top_w      = ramp_q == RAMP_CEILING_LEVEL;
	assign period_end = step_w & top_w;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pre_q  <= '0;
			ramp_q <= RAMP_FLOOR_LEVEL;
		end else begin
			pre_q <= step_w ? '0 : pre_q + 1'b1;
			if (step_w) begin
				ramp_q <= top_w ? RAMP_FLOOR_LEVEL : ramp_q + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	ramp_wrap_a: assert property (period_end |=> ramp_q == RAMP_FLOOR_LEVEL)
		else $error("ramp did not return to floor after period end");

endmodule

/* File: logic/fpfc_sense.sv */
// Fan pulse synchroniser, edge detector and turn-on blanker
module fpfc_sense
	import fpfc_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Pins
	input  wire logic sense,
	input  wire logic drive,
	// Qualified pulse
	output logic      pulse_q
);

	logic               sync1_q;
	logic               sync2_q;
	logic               prev_q;
	logic               drive_prev_q;
	logic               first_q;
	logic [BLANK_W-1:0] blank_q;
	wire                rise_w;
	wire                turn_on_w;
	wire                open_w;

	assign rise_w    = sync2_q & ~prev_q;
	assign turn_on_w = drive & ~drive_prev_q;
	assign open_w    = (blank_q == '0) & ~turn_on_w;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_q      <= 1'b0;
			sync2_q      <= 1'b0;
			prev_q       <= 1'b0;
			drive_prev_q <= 1'b0;
			first_q      <= 1'b1;
			blank_q      <= '0;
			pulse_q      <= 1'b0;
		end else begin
			sync1_q      <= sense;
			sync2_q      <= sync1_q;
			prev_q       <= sync2_q;
			drive_prev_q <= drive;
			if (turn_on_w) begin
				blank_q <= BLANK_W'(BLANK_CYCLES);
				first_q <= 1'b1;
			end else begin
				if (blank_q != '0) begin
					blank_q <= blank_q - 1'b1;
				end
				if (rise_w && open_w) begin
					first_q <= 1'b0;
				end
			end
			pulse_q <= rise_w & open_w & ~first_q;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	pulse_single_a: assert property (pulse_q |=> !pulse_q)
		else $error("one fan edge counted twice");
	blank_gate_a: assert property ($rose(drive) |=> !pulse_q [*2])
		else $error("pulse accepted inside turn-on blanking");

endmodule

/* File: testbench/fpfc_fan_model.sv */
// Fan, current sense and pulled-up fault wire seen from the controller pins
module fpfc_fan_model (
	// Clock
	input  wire logic clock,
	// Bench control
	input  wire logic spin,
	// Fan pins
	output logic      sense,
	// Open-drain fault wire
	input  wire logic fault_out,
	input  wire logic fault_oe,
	output logic      fault_in
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [5:0] phase_q;

	// ==========================================================
	// Commutation pulses every 40 clocks while spinning
	initial begin
		phase_q = 6'h00;
		sense = 1'b0;
	end
	always @(posedge clock) begin
		phase_q <= (phase_q == 6'h27) ? 6'h00 : phase_q + 6'h01;
		sense <= spin && (phase_q < 6'h08);
	end

	// ==========================================================
	// Pull-up wins unless the controller sinks the wire
	assign fault_in = fault_oe ? fault_out : 1'b1;
endmodule

/* File: testbench/fan_pwm_fault_controller_tb_top.sv */
// Self-checking bench for the fan PWM fault controller
module fan_pwm_fault_controller_tb_top
	import fpfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int STEP = 4;
	localparam int PWM  = 128 * STEP;

	logic        clock;
	logic        rst_n;
	logic        read;
	logic        write;
	logic        spin;
	logic [3:0]  address;
	logic [3:0]  byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic [31:0] q;
	logic [31:0] n;
	logic [31:0] seed;
	logic        waitrequest;
	logic        sense;
	logic        drive_q;
	logic        fault_in;
	logic        fault_out;
	logic        fault_oe;
	logic [7:0]  t;
	logic [7:0]  m;
	logic [15:0] corner [4] = '{16'h4040, 16'h4140, 16'hBE40, 16'h40BF};
	int          mismatches;
	int          checked;
	int          k;

	always #25 clock = ~clock;

	fpfc_controller #(.STEP_CYCLES(STEP)) dut_u (
		.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .sense(sense), .drive_q(drive_q), .fault_in(fault_in),
		.fault_out(fault_out), .fault_oe(fault_oe)
	);

	fpfc_fan_model fan_u (
		.clock(clock), .spin(spin), .sense(sense), .fault_out(fault_out),
		.fault_oe(fault_oe), .fault_in(fault_in)
	);

	// ==========================================================
	// Reporting
	task print_verdict;
		$display("Counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task timeout;
		mismatches++;
		print_verdict();
	endtask

	// ==========================================================
	// Avalon-MM master, held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		int w;
		@(posedge clock);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		w = 0;
		do begin
			@(posedge clock);
			w++;
		end while (waitrequest !== 1'b0 && w < 20);
		if (w >= 20)
			timeout();
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task status;
		bus(1'b0, REG_STATUS, 32'h0, 4'hF);
	endtask

	task set_level(input logic [7:0] tv, input logic [7:0] mv);
		bus(1'b1, REG_LEVEL, {16'h0, mv, tv}, 4'h3);
	endtask

	task wait_state(input logic [2:0] s, input int bound);
		k = 0;
		do begin
			status();
			k++;
		end while (q[10:8] !== s && k < bound);
		if (k >= bound)
			timeout();
	endtask

	task window_len;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (fault_oe !== 1'b1 && k < 40 * PWM);
		if (k >= 40 * PWM)
			timeout();
	endtask

	task measure;
		n = 32'h0;
		repeat (PWM) begin
			@(posedge clock);
			n += (drive_q === 1'b1);
		end
	endtask

	// ==========================================================
	// Expectations
	function logic [31:0] duty(input logic [7:0] tv, input logic [7:0] mv);
		logic [7:0] l;
		l = (tv > mv) ? tv : mv;
		if (l <= 8'h40)
			return 32'h0;
		if (l >= 8'hBF)
			return PWM;
		return STEP * (l - 8'h40);
	endfunction

	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0;
		byteenable = 4'h0;
		spin = 1'b0;
		seed = 32'h8A8B;
		mismatches = 0;
		checked = 0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		window_len();
		check("powerup window", (k >= 32 * PWM - 16 && k <= 32 * PWM + 8), 1);
		check("fault drive", drive_q, 1);
		$display("Test powerup done");
		set_level(8'h40, 8'h07);
		repeat (4) @(posedge clock);
		check("shutdown drive", drive_q, 0);
		check("shutdown fault", fault_oe, 0);
		status();
		check("shutdown state", q[10:8], ST_SHUTDOWN);
		check("fault wire", q[4], 1);
		check("fault data", fault_out, 0);
		set_level(8'h40, 8'h60);
		wait_state(ST_STARTUP, 400);
		check("release state", q[10:8], ST_STARTUP);
		window_len();
		check("release window", (k >= 32 * PWM - 16 && k <= 32 * PWM + 8), 1);
		measure();
		check("fault duty", n, PWM);
		check("fault held", fault_oe, 1);
		$display("Test shutdown done");
		spin <= 1'b1;
		wait_state(ST_RUN, 12000);
		check("recover fault", fault_oe, 0);
		repeat (PWM) @(posedge clock);
		measure();
		check("min duty", n, duty(8'h40, 8'h60));
		$display("Test recovery done");
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			{t, m} = (i < 4) ? corner[i] : {seed[7:0] & 8'hBF, seed[15:8] & 8'h7F | 8'h20};
			set_level(t, m);
			repeat (PWM) @(posedge clock);
			measure();
			check("duty", n, duty(t, m));
		end
		status();
		check("still run", q[10:8], ST_RUN);
		$display("Test duty done");
		set_level(8'hC1, 8'h40);
		repeat (3) @(posedge clock);
		check("overtemp set", fault_oe, 1);
		set_level(8'hBA, 8'h40);
		repeat (3) @(posedge clock);
		check("overtemp hold", fault_oe, 1);
		set_level(8'hB9, 8'h40);
		repeat (3) @(posedge clock);
		check("overtemp clear", fault_oe, 0);
		bus(1'b0, REG_LEVEL, 32'h0, 4'hF);
		check("level read", q, 32'h000040B9);
		bus(1'b0, 4'hC, 32'h0, 4'hF);
		check("unmapped read", q, 32'h0);
		$display("Test overtemp done");
		spin <= 1'b0;
		wait_state(ST_DIAG, 12000);
		check("diag drive", drive_q, 1);
		spin <= 1'b1;
		wait_state(ST_RUN, PWM);
		check("diag fault", fault_oe, 0);
		$display("Test diagnostic done");
		print_verdict();
	end
endmodule
